/* File: logic/wgr_params.svh */
`ifndef WGR_PARAMS_SVH
`define WGR_PARAMS_SVH
// Register byte offsets: group in address bits 5:4, channel or index in 3:2
`define WGR_GRP_FCFG   2'h0
`define WGR_GRP_LIM    2'h1
`define WGR_GRP_MISC   2'h2
`define WGR_GRP_CODE   2'h3
`define WGR_IDX_SHARED 2'h0
`define WGR_IDX_ACTION 2'h1
`define WGR_IDX_STATE  2'h2
// Channel function settings fields
`define WGR_WAVE       2:0
`define WGR_RATE       6:3
`define WGR_INC        9:7
`define WGR_PHASE      11:10
`define WGR_GAIN       14:12
// Limit register fields
`define WGR_LO         11:0
`define WGR_HI         27:16
// Shared settings and action strobe fields
`define WGR_SH_PROT    0
`define WGR_SH_PINRST  1
`define WGR_ACT_RST    3:0
`define WGR_ACT_KEY    7:4
`define WGR_ACT_PROG   8
// Codes
`define WGR_WAVE_TRI   3'h0
`define WGR_WAVE_SAW   3'h1
`define WGR_WAVE_INV   3'h2
`define WGR_WAVE_SINE  3'h4
`define WGR_RST_CODE   4'ha
`define WGR_KEY_CODE   4'h5
// Factory reset values
`define WGR_FCFG_RST   16'h0000
`define WGR_LIM_RST    32'h0fff_0000
`define WGR_SHARED_RST 2'h0
// Store check
`define WGR_CRC_POLY   16'h1021
`define WGR_CRC_INIT   16'hffff
`define WGR_NVM_LAST   4'h8
// Sine table
`define WGR_SINE_LAST  5'h17
`define WGR_PHASE_STEP 5'h06
// Timing: clock period and step periods in ns
`define WGR_CLK_NS     4
`define WGR_NS2CYC(t)  (((t) + `WGR_CLK_NS - 1) / `WGR_CLK_NS)
`define WGR_STEP_NS_1  4000
`define WGR_STEP_NS_2  8000
`define WGR_STEP_NS_3  12000
`define WGR_STEP_NS_4  18000
`define WGR_STEP_NS_5  27000
`define WGR_STEP_NS_6  40500
`define WGR_STEP_NS_7  60750
`define WGR_STEP_NS_8  91130
`define WGR_STEP_NS_9  136690
`define WGR_STEP_NS_10 239200
`define WGR_STEP_NS_11 418610
`define WGR_STEP_NS_12 732560
`define WGR_STEP_NS_13 1281980
`define WGR_STEP_NS_14 2563960
`define WGR_STEP_NS_15 5127920
`endif

/* File: logic/wgr_pkg.sv */
package wgr_pkg;
  // Boot and store sequencer
  typedef enum logic [4:0] {
    wgr_st_run   = 5'b00001,
    wgr_st_boot  = 5'b00010,
    wgr_st_crc   = 5'b00100,
    wgr_st_apply = 5'b01000,
    wgr_st_prog  = 5'b10000
  } wgr_boot_e;

  // Per-channel output to the converter
  typedef struct packed {
    logic [11:0] code;
    logic [2:0]  gain;
  } wgr_chan_s;

  // Whole block state
  typedef struct packed {
    wgr_boot_e        boot;
    logic [3:0]       widx;
    logic [15:0]      crc;
    logic             prog;
    logic             unlock;
    logic             ualarm;
    logic             falarm;
    logic [3:0][15:0] fcfg;
    logic [3:0][31:0] lim;
    logic [1:0]       shared;
    logic [3:0][15:0] nfcfg;
    logic [3:0][31:0] nlim;
    logic [1:0]       nshared;
    logic [15:0]      ncrc;
    logic [3:0][11:0] code;
    logic [3:0]       down;
    logic [3:0][4:0]  sidx;
    logic [3:0][20:0] cnt;
    logic             waitreq;
    logic [31:0]      rdata;
    logic             rs1;
    logic             rs2;
    logic             rprev;
    logic             us1;
    logic             us2;
    logic             fs1;
    logic             fs2;
  } wgr_state_s;
endpackage

/* File: logic/wgr_core.sv */
`timescale 1ns/1ns
`include "wgr_params.svh"

module wgr_core #(
  parameter int unsigned STEP_CYC [16] = '{1,
    `WGR_NS2CYC(`WGR_STEP_NS_1),  `WGR_NS2CYC(`WGR_STEP_NS_2),  `WGR_NS2CYC(`WGR_STEP_NS_3),
    `WGR_NS2CYC(`WGR_STEP_NS_4),  `WGR_NS2CYC(`WGR_STEP_NS_5),  `WGR_NS2CYC(`WGR_STEP_NS_6),
    `WGR_NS2CYC(`WGR_STEP_NS_7),  `WGR_NS2CYC(`WGR_STEP_NS_8),  `WGR_NS2CYC(`WGR_STEP_NS_9),
    `WGR_NS2CYC(`WGR_STEP_NS_10), `WGR_NS2CYC(`WGR_STEP_NS_11), `WGR_NS2CYC(`WGR_STEP_NS_12),
    `WGR_NS2CYC(`WGR_STEP_NS_13), `WGR_NS2CYC(`WGR_STEP_NS_14), `WGR_NS2CYC(`WGR_STEP_NS_15)}
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              reset_pin_n,
  input  wire logic              ustore_fault,
  input  wire logic              fstore_fault,
  output wgr_pkg::wgr_chan_s [3:0] chan_out
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Code increment table
  function automatic logic [11:0] inc_dec(input logic [2:0] sel);
    case (sel)
      3'h0:    return 12'h001;
      3'h1:    return 12'h002;
      3'h2:    return 12'h003;
      3'h3:    return 12'h004;
      3'h4:    return 12'h006;
      3'h5:    return 12'h008;
      3'h6:    return 12'h010;
      default: return 12'h020;
    endcase
  endfunction

  // Last count of the dwell counter for a step period
  function automatic logic [20:0] step_last(input logic [3:0] sel);
    return 21'(STEP_CYC[sel] - 1);
  endfunction

  // Fixed sine points; amplitude only through the gain field downstream
  function automatic logic [11:0] sine_pt(input logic [4:0] idx);
    case (idx)
      5'h00:   return 12'h800;
      5'h01:   return 12'h9a8;
      5'h02:   return 12'hb33;
      5'h03:   return 12'hc87;
      5'h04:   return 12'hd8b;
      5'h05:   return 12'he2f;
      5'h06:   return 12'he66;
      5'h07:   return 12'he2f;
      5'h08:   return 12'hd8b;
      5'h09:   return 12'hc87;
      5'h0a:   return 12'hb33;
      5'h0b:   return 12'h9a8;
      5'h0c:   return 12'h800;
      5'h0d:   return 12'h658;
      5'h0e:   return 12'h4cd;
      5'h0f:   return 12'h379;
      5'h10:   return 12'h275;
      5'h11:   return 12'h1d1;
      5'h12:   return 12'h19a;
      5'h13:   return 12'h1d1;
      5'h14:   return 12'h275;
      5'h15:   return 12'h379;
      5'h16:   return 12'h4cd;
      default: return 12'h658;
    endcase
  endfunction

  // One 32-bit word through CRC-16-CCITT, MSB first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 31; b >= 0; b--) begin
      r = (r[15] ^ d[b]) ? ({r[14:0], 1'b0} ^ `WGR_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // Word of the store image by index
  function automatic logic [31:0] nvm_word(input wgr_pkg::wgr_state_s s, input logic [3:0] i);
    if (i < 4'h4) begin
      return {16'h0000, s.nfcfg[i[1:0]]};
    end else if (i < 4'h8) begin
      return s.nlim[i[1:0]];
    end
    return {30'h0000_0000, s.nshared};
  endfunction

  // Read decode
  function automatic logic [31:0] rd_word(input wgr_pkg::wgr_state_s s, input logic [5:0] a);
    case (a[5:4])
      `WGR_GRP_FCFG: return {16'h0000, s.fcfg[a[3:2]]};
      `WGR_GRP_LIM:  return s.lim[a[3:2]];
      `WGR_GRP_CODE: return {20'h0_0000, s.code[a[3:2]]};
      default: begin
        case (a[3:2])
          `WGR_IDX_SHARED: return {30'h0000_0000, s.shared};
          `WGR_IDX_STATE:  return {29'h0000_0000, s.boot != wgr_pkg::wgr_st_run,
                                   s.falarm, s.ualarm};
          default:         return 32'h0000_0000;
        endcase
      end
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************

  localparam wgr_pkg::wgr_state_s ST_RST = '{
    boot:    wgr_pkg::wgr_st_prog,
    lim:     {4{`WGR_LIM_RST}},
    nlim:    {4{`WGR_LIM_RST}},
    waitreq: 1'b1,
    rs1:     1'b1,
    rs2:     1'b1,
    rprev:   1'b1,
    default: '0
  };

  wgr_pkg::wgr_state_s st_ff;
  wgr_pkg::wgr_state_s nxt_st;
  logic [3:0]          restart;
  logic                wr_take;
  logic                locked;
  logic                pin_fall;
  logic                is_action;

  // Write lands on the edge where the master sees waitrequest low
  assign wr_take   = avs_write & ~st_ff.waitreq;
  assign locked    = st_ff.shared[`WGR_SH_PROT] & ~st_ff.unlock;
  assign is_action = (avs_address[5:4] == `WGR_GRP_MISC) && (avs_address[3:2] == `WGR_IDX_ACTION);
  // Falling edge only; rising edge is ignored
  assign pin_fall  = st_ff.rprev & ~st_ff.rs2 & st_ff.shared[`WGR_SH_PINRST];

  // ****************************************
  // Next-state logic
  // ****************************************

  always_comb begin
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] inc;
    logic [12:0] sum;
    logic [12:0] lo_inc;
    logic [4:0]  nidx;
    logic        ubad;
    lo      = '0;
    hi      = '0;
    inc     = '0;
    sum     = '0;
    lo_inc  = '0;
    nidx    = '0;
    ubad    = 1'b0;
    nxt_st  = st_ff;
    restart = '0;

    // Pin inputs, two flops before use
    nxt_st.rs1   = reset_pin_n;
    nxt_st.rs2   = st_ff.rs1;
    nxt_st.rprev = st_ff.rs2;
    nxt_st.us1   = ustore_fault;
    nxt_st.us2   = st_ff.us1;
    nxt_st.fs1   = fstore_fault;
    nxt_st.fs2   = st_ff.fs1;

    // Bus answers only while running; host is held off during boot
    nxt_st.waitreq = 1'b1;
    if ((st_ff.boot == wgr_pkg::wgr_st_run) && (avs_read | avs_write) && st_ff.waitreq) begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata   = rd_word(st_ff, avs_address);
    end

    // Register writes
    if (wr_take) begin
      if (is_action) begin
        if (avs_writedata[`WGR_ACT_KEY] == `WGR_KEY_CODE) begin
          nxt_st.unlock = 1'b1;
        end
        if (avs_writedata[`WGR_ACT_RST] == `WGR_RST_CODE) begin
          nxt_st.boot = wgr_pkg::wgr_st_boot;
        end else if (avs_writedata[`WGR_ACT_PROG] && !locked) begin
          nxt_st.boot = wgr_pkg::wgr_st_prog;
        end
      end else if (!locked) begin
        case (avs_address[5:4])
          `WGR_GRP_FCFG: begin
            nxt_st.fcfg[avs_address[3:2]] = avs_writedata[15:0];
            restart[avs_address[3:2]]     = 1'b1;
          end
          `WGR_GRP_LIM: begin
            nxt_st.lim[avs_address[3:2]] = avs_writedata & {4'h0, 12'hfff, 4'h0, 12'hfff};
            restart[avs_address[3:2]]    = 1'b1;
          end
          `WGR_GRP_MISC: begin
            if (avs_address[3:2] == `WGR_IDX_SHARED) begin
              nxt_st.shared = avs_writedata[1:0];
            end
          end
          default: ;
        endcase
      end
    end

    // Boot and store sequencer
    case (st_ff.boot)
      wgr_pkg::wgr_st_run: ;
      wgr_pkg::wgr_st_boot: begin
        nxt_st.ualarm = 1'b0;
        nxt_st.falarm = 1'b0;
        nxt_st.unlock = 1'b0;
        nxt_st.widx   = '0;
        nxt_st.crc    = `WGR_CRC_INIT;
        nxt_st.prog   = 1'b0;
        nxt_st.boot   = wgr_pkg::wgr_st_crc;
      end
      wgr_pkg::wgr_st_prog: begin
        // Copy live settings into the store, then sign them
        nxt_st.nfcfg   = st_ff.fcfg;
        nxt_st.nlim    = st_ff.lim;
        nxt_st.nshared = st_ff.shared;
        nxt_st.widx    = '0;
        nxt_st.crc     = `WGR_CRC_INIT;
        nxt_st.prog    = 1'b1;
        nxt_st.boot    = wgr_pkg::wgr_st_crc;
      end
      wgr_pkg::wgr_st_crc: begin
        // Readback fault flips bit 0 of every word seen by the boot check; a store programming pass is not affected
        nxt_st.crc  = crc16(st_ff.crc, nvm_word(st_ff, st_ff.widx)
                            ^ {31'h0000_0000, st_ff.us2 & ~st_ff.prog});
        nxt_st.widx = st_ff.widx + 4'h1;
        if (st_ff.widx == `WGR_NVM_LAST) begin
          nxt_st.boot = wgr_pkg::wgr_st_apply;
        end
      end
      wgr_pkg::wgr_st_apply: begin
        nxt_st.boot = wgr_pkg::wgr_st_run;
        if (st_ff.prog) begin
          nxt_st.ncrc = st_ff.crc;
        end else begin
          ubad    = st_ff.crc != st_ff.ncrc;
          restart = 4'hf;
          if (ubad | st_ff.fs2) begin
            nxt_st.fcfg   = {4{`WGR_FCFG_RST}};
            nxt_st.lim    = {4{`WGR_LIM_RST}};
            nxt_st.shared = `WGR_SHARED_RST;
            nxt_st.ualarm = ubad;
            nxt_st.falarm = st_ff.fs2;
          end else begin
            nxt_st.fcfg   = st_ff.nfcfg;
            nxt_st.lim    = st_ff.nlim;
            nxt_st.shared = st_ff.nshared;
          end
        end
      end
      default: nxt_st.boot = wgr_pkg::wgr_st_boot;
    endcase

    if (pin_fall) begin
      nxt_st.boot = wgr_pkg::wgr_st_boot;
    end

    // Waveform generators; restart uses the settings about to be registered
    for (int i = 0; i < 4; i++) begin
      lo     = nxt_st.lim[i][`WGR_LO];
      hi     = nxt_st.lim[i][`WGR_HI];
      inc    = inc_dec(nxt_st.fcfg[i][`WGR_INC]);
      if (restart[i]) begin
        nxt_st.cnt[i]  = step_last(nxt_st.fcfg[i][`WGR_RATE]);
        nxt_st.down[i] = 1'b0;
        nxt_st.sidx[i] = 5'(`WGR_PHASE_STEP * nxt_st.fcfg[i][`WGR_PHASE]);
        case (nxt_st.fcfg[i][`WGR_WAVE])
          `WGR_WAVE_INV:  nxt_st.code[i] = hi;
          `WGR_WAVE_SINE: nxt_st.code[i] = sine_pt(nxt_st.sidx[i]);
          default:        nxt_st.code[i] = lo;
        endcase
      end else if (st_ff.boot == wgr_pkg::wgr_st_run) begin
        sum    = {1'b0, st_ff.code[i]} + {1'b0, inc};
        lo_inc = {1'b0, lo} + {1'b0, inc};
        nidx   = (st_ff.sidx[i] == `WGR_SINE_LAST) ? 5'h00 : st_ff.sidx[i] + 5'h01;
        if (st_ff.cnt[i] != 21'h00_0000) begin
          nxt_st.cnt[i] = st_ff.cnt[i] - 21'h00_0001;
        end else begin
          nxt_st.cnt[i] = step_last(st_ff.fcfg[i][`WGR_RATE]);
          case (st_ff.fcfg[i][`WGR_WAVE])
            `WGR_WAVE_SAW: begin
              nxt_st.code[i] = (sum > {1'b0, hi}) ? lo : sum[11:0];
            end
            `WGR_WAVE_INV: begin
              nxt_st.code[i] = ({1'b0, st_ff.code[i]} < lo_inc) ? hi
                                                              : st_ff.code[i] - inc;
            end
            `WGR_WAVE_SINE: begin
              nxt_st.sidx[i] = nidx;
              nxt_st.code[i] = sine_pt(nidx);
            end
            `WGR_WAVE_TRI: begin
              if (!st_ff.down[i]) begin
                nxt_st.code[i] = (sum >= {1'b0, hi}) ? hi : sum[11:0];
                nxt_st.down[i] = sum >= {1'b0, hi};
              end else begin
                nxt_st.code[i] = ({1'b0, st_ff.code[i]} < lo_inc) ? lo : st_ff.code[i] - inc;
                nxt_st.down[i] = !({1'b0, st_ff.code[i]} < lo_inc);
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Clock enable low freezes every flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= ST_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;

  // Gain travels with the code; it alone scales the sine
  for (genvar g = 0; g < 4; g++) begin : g_out
    assign chan_out[g].code = st_ff.code[g];
    assign chan_out[g].gain = st_ff.fcfg[g][`WGR_GAIN];
  end

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic        tk0;
  logic [2:0]  sel0;
  logic [11:0] inc0;
  logic [12:0] sum0;
  assign tk0  = ce && (st_ff.boot == wgr_pkg::wgr_st_run) && (st_ff.cnt[0] == 21'h00_0000)
                && !restart[0];
  assign sel0 = st_ff.fcfg[0][`WGR_WAVE];
  assign inc0 = inc_dec(st_ff.fcfg[0][`WGR_INC]);
  assign sum0 = {1'b0, st_ff.code[0]} + {1'b0, inc0};

  sequence s_boot_start;
    (st_ff.boot == wgr_pkg::wgr_st_boot) ##1 (st_ff.boot == wgr_pkg::wgr_st_crc);
  endsequence

  property p_saw_step;
    tk0 && (sel0 == `WGR_WAVE_SAW) && (sum0 <= {1'b0, st_ff.lim[0][`WGR_HI]})
    |=> st_ff.code[0] == 12'($past(st_ff.code[0]) + $past(inc0));
  endproperty
  a_saw_step: assert property (p_saw_step) else $error("sawtooth step wrong");

  property p_saw_wrap;
    tk0 && (sel0 == `WGR_WAVE_SAW) && (sum0 > {1'b0, st_ff.lim[0][`WGR_HI]})
    |=> st_ff.code[0] == $past(st_ff.lim[0][`WGR_LO]);
  endproperty
  a_saw_wrap: assert property (p_saw_wrap) else $error("sawtooth wrap wrong");

  property p_inv_step;
    tk0 && (sel0 == `WGR_WAVE_INV)
    && ({1'b0, st_ff.code[0]} >= {1'b0, st_ff.lim[0][`WGR_LO]} + {1'b0, inc0})
    |=> st_ff.code[0] == 12'($past(st_ff.code[0]) - $past(inc0));
  endproperty
  a_inv_step: assert property (p_inv_step) else $error("inverse step wrong");

  property p_sine;
    tk0 && (sel0 == `WGR_WAVE_SINE)
    |=> st_ff.code[0] == sine_pt(st_ff.sidx[0]) && (st_ff.sidx[0] ==
        (($past(st_ff.sidx[0]) == `WGR_SINE_LAST) ? 5'h00 : $past(st_ff.sidx[0]) + 5'h01));
  endproperty
  a_sine: assert property (p_sine) else $error("sine step wrong");

  property p_hold;
    ce && (st_ff.boot == wgr_pkg::wgr_st_run) && (st_ff.cnt[0] != 21'h00_0000) && !restart[0]
    |=> $stable(st_ff.code[0]) && (st_ff.cnt[0] == $past(st_ff.cnt[0]) - 21'h00_0001);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved inside dwell");

  property p_phase;
    ce && restart[0] && (nxt_st.fcfg[0][`WGR_WAVE] == `WGR_WAVE_SINE)
    |=> st_ff.sidx[0] == 5'(`WGR_PHASE_STEP * st_ff.fcfg[0][`WGR_PHASE]);
  endproperty
  a_phase: assert property (p_phase) else $error("sine phase start wrong");

  property p_lock;
    ce && wr_take && locked && (avs_address[5:4] == `WGR_GRP_FCFG)
    && (st_ff.boot == wgr_pkg::wgr_st_run) |=> $stable(st_ff.fcfg);
  endproperty
  a_lock: assert property (p_lock) else $error("write passed protection");

  property p_key;
    ce && wr_take && is_action && (avs_writedata[`WGR_ACT_KEY] == `WGR_KEY_CODE)
    && (st_ff.boot == wgr_pkg::wgr_st_run) && !pin_fall |=> st_ff.unlock;
  endproperty
  a_key: assert property (p_key) else $error("bypass key ignored");

  property p_swrst;
    ce && wr_take && is_action && (avs_writedata[`WGR_ACT_RST] == `WGR_RST_CODE)
    |=> ce [*1] ##0 s_boot_start or !ce;
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset not started");

  property p_pin;
    ce && pin_fall |=> st_ff.boot == wgr_pkg::wgr_st_boot;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset not started");

  property p_alarm_run;
    ce && (st_ff.boot == wgr_pkg::wgr_st_run) |=> $stable({st_ff.ualarm, st_ff.falarm});
  endproperty
  a_alarm_run: assert property (p_alarm_run) else $error("alarm moved outside boot");

  property p_alarm_clr;
    ce && (st_ff.boot == wgr_pkg::wgr_st_boot) |=> !st_ff.ualarm && !st_ff.falarm;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarms not cleared");

  property p_ufail;
    ce && (st_ff.boot == wgr_pkg::wgr_st_apply) && !st_ff.prog && (st_ff.crc != st_ff.ncrc)
    |=> st_ff.ualarm && (st_ff.fcfg[0] == `WGR_FCFG_RST) && (st_ff.lim[0] == `WGR_LIM_RST);
  endproperty
  a_ufail: assert property (p_ufail) else $error("user check fail mishandled");

  property p_ffail;
    ce && (st_ff.boot == wgr_pkg::wgr_st_apply) && !st_ff.prog && st_ff.fs2
    |=> st_ff.falarm && (st_ff.shared == `WGR_SHARED_RST);
  endproperty
  a_ffail: assert property (p_ffail) else $error("factory check fail mishandled");

  property p_load;
    ce && (st_ff.boot == wgr_pkg::wgr_st_apply) && !st_ff.prog && !st_ff.fs2
    && (st_ff.crc == st_ff.ncrc) |=> (st_ff.fcfg == $past(st_ff.nfcfg)) && !st_ff.ualarm;
  endproperty
  a_load: assert property (p_load) else $error("store not loaded at boot");

  property p_sign;
    ce && (st_ff.boot == wgr_pkg::wgr_st_apply) && st_ff.prog |=> st_ff.ncrc == $past(st_ff.crc);
  endproperty
  a_sign: assert property (p_sign) else $error("store check word not kept");

endmodule

/* File: sim/test_waveform_gen_reset_fault_ctrl.sv */
`timescale 1ns/1ns
module test_waveform_gen_reset_fault_ctrl;
  // ****************
  // Signals
  // ****************
  logic                     mclk = 0;
  logic                     rst_b = 0;
  logic [5:0]               avs_address = 0;
  logic                     avs_read = 0;
  logic                     avs_write = 0;
  logic [31:0]              avs_writedata = 0;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  logic                     reset_pin_n = 1;
  logic                     ce = 1;
  logic                     ustore_fault = 0;
  logic                     fstore_fault = 0;
  wgr_pkg::wgr_chan_s [3:0] chan_out;
  int                       fails = 0;
  int                       checks_done = 0;
  logic [31:0]              rv;
  localparam logic [11:0] TAB [24] = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f,
    12'he66, 12'he2f, 12'hd8b, 12'hc87, 12'hb33, 12'h9a8, 12'h800, 12'h658, 12'h4cd, 12'h379,
    12'h275, 12'h1d1, 12'h19a, 12'h1d1, 12'h275, 12'h379, 12'h4cd, 12'h658};
  // Short step table keeps every dwell a few cycles
  wgr_core #(.STEP_CYC('{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16})) u_wgr_core (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reset_pin_n(reset_pin_n),
    .ustore_fault(ustore_fault), .fstore_fault(fstore_fault), .chan_out(chan_out));
  // Clock
  always #2 mclk = ~mclk;
  // ****************
  // Helpers
  // ****************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Bus cycles; no cycle count assumed, the watchdog cuts a hang
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a; avs_writedata <= d; avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task rd(input logic [5:0] a);
    @(posedge mclk);
    avs_address <= a; avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // Follow one channel through 12 code changes; w selects the shape
  task watch(input int ch, input logic [2:0] w, input logic [11:0] lo, input logic [11:0] hi,
             input int per);
    logic [11:0] o, e;
    logic        up;
    int          c, k, d;
    o = chan_out[ch].code; up = 1; c = 0; k = 0;
    while (k < 12) begin
      @(posedge mclk);
      c++;
      if (chan_out[ch].code !== o) begin
        d = per;
        if (w == 3'h1) e = (o == hi) ? lo : o + 12'h001;
        else if (w == 3'h2) e = (o == lo) ? hi : o - 12'h001;
        else begin
          if (o == hi) up = 0;
          // Triangle floor is held a second step before it climbs again
          if (o == lo && !up) d = 2 * per;
          if (o == lo) up = 1;
          e = up ? o + 12'h001 : o - 12'h001;
        end
        chk("step", {20'h0, chan_out[ch].code}, {20'h0, e});
        if (k > 0) chk("dwell", 32'(c), 32'(d));
        o = chan_out[ch].code; c = 0; k++;
      end
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task reg_defaults;
    rd(6'h00); chk("fcfg0", rv, 32'h0);
    rd(6'h10); chk("lim0", rv, 32'h0fff_0000);
    rd(6'h20); chk("shared", rv, 32'h0);
    rd(6'h28); chk("state", rv, 32'h0);
    rd(6'h2c); chk("unmapped", rv, 32'h0);
  endtask
  task ramps;
    wr(6'h10, 32'h0802_07fe);
    wr(6'h00, 32'h0000_0011);
    repeat (2) @(posedge mclk);
    watch(0, 3'h1, 12'h7fe, 12'h802, 3);
    wr(6'h00, 32'h0000_0012);
    repeat (2) @(posedge mclk);
    watch(0, 3'h2, 12'h7fe, 12'h802, 3);
    wr(6'h18, 32'h0103_0100);
    wr(6'h08, 32'h0000_0008);
    repeat (2) @(posedge mclk);
    watch(2, 3'h0, 12'h100, 12'h103, 2);
  endtask
  task sine;
    for (int p = 0; p < 4; p++) begin
      wr(6'h04, 32'h0000_507c | (p << 10));
      repeat (3) @(posedge mclk);
      chk("phase", {20'h0, chan_out[1].code}, {20'h0, TAB[6 * p]});
      chk("gain", {29'h0, chan_out[1].gain}, 32'h5);
      rd(6'h34); chk("codereg", rv, {20'h0, TAB[6 * p]});
    end
    // One step per cycle, so the whole table passes in 24 cycles
    wr(6'h04, 32'h0000_5004);
    while (chan_out[1].code !== 12'h800) @(posedge mclk);
    for (int i = 1; i < 26; i++) begin
      @(posedge mclk);
      chk("sine", {20'h0, chan_out[1].code}, {20'h0, TAB[i % 24]});
    end
    // Clock enable low must freeze the sine that steps every cycle
    ce <= 1'b0;
    @(posedge mclk);
    rv = {20'h0, chan_out[1].code};
    repeat (4) @(posedge mclk);
    chk("freeze", {20'h0, chan_out[1].code}, rv);
    ce <= 1'b1;
  endtask
  task lock;
    wr(6'h20, 32'h1);
    wr(6'h00, 32'h11);
    rd(6'h00); chk("locked", rv, 32'h12);
    // Reset code goes through while still protected and without the key
    wr(6'h24, 32'ha);
    rd(6'h00); chk("swreset", rv, 32'h0);
    wr(6'h20, 32'h1);
    wr(6'h24, 32'h50);
    wr(6'h00, 32'h11);
    rd(6'h00); chk("bypass", rv, 32'h11);
  endtask
  task faults;
    for (int f = 0; f < 2; f++) begin
      ustore_fault <= (f == 0);
      fstore_fault <= (f == 1);
      wr(6'h24, 32'ha);
      rd(6'h28); chk("alarm", rv, 32'h1 << f);
      wr(6'h00, 32'h11);
      rd(6'h00); chk("writable", rv, 32'h11);
      ustore_fault <= 1'b0;
      fstore_fault <= 1'b0;
      wr(6'h24, 32'ha);
      rd(6'h28); chk("cleared", rv, 32'h0);
    end
    // A fault outside boot leaves the alarms alone
    ustore_fault <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(6'h28); chk("runfault", rv, 32'h0);
    ustore_fault <= 1'b0;
  endtask
  task pin;
    wr(6'h20, 32'h2);
    wr(6'h24, 32'h100);
    wr(6'h00, 32'h11);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(6'h00); chk("pinfall", rv, 32'h0);
    rd(6'h20); chk("pinkept", rv, 32'h2);
    wr(6'h00, 32'h11);
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(6'h00); chk("pinrise", rv, 32'h11);
  endtask
  // ****************
  // Run control
  // ****************
  task report_and_stop;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    reg_defaults;
    ramps;
    sine;
    lock;
    faults;
    pin;
    report_and_stop;
  end
  // Watchdog, far beyond the expected run
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
endmodule
